// ### common/cspc_params.svh
// Purpose: Constants of the charger status and pin control block
// Assumes: 20 MHz system clock, word-aligned register port
// Notes:   Operation
// Operation
// R1: Charging in progress pulls status pin low
// R2: Done or sleep releases status pin high
// R3: Fault suspend blinks status at 1Hz, 50%
// R4: Status pin mode field disables status drive
// R5: Update or fault gives 256us alert low pulse
// R6: Charge enabled when allow bit 1, pin low
// R7: Source pin high 500mA, low 2.4A default
// R8: Host written current limit overrides pin default
// R9: Supply ok low only for good input
// R10: Each data line level from its field
// R11: Status, alert, supply ok only pull low
// R12: Timing by clock counts; fault has priority
`ifndef CSPC_PARAMS_SVH
`define CSPC_PARAMS_SVH
// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define CSPC_CLK_HZ        20000000
`define CSPC_ALERT_US      256
`define CSPC_BLINK_HZ      1
`define CSPC_CNT_W         24
// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define CSPC_A_CTRL        8'h00
`define CSPC_A_INPUT_LIMIT_SETTING        8'h04
`define CSPC_A_STATUS      8'h08
`define CSPC_A_INT_STAT    8'h0c
`define CSPC_A_INT_CLR     8'h10
`define CSPC_A_INT_EN      8'h14
// -----------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------
`define CSPC_CTRL_RST      8'h01
`define CSPC_CTRL_ALLOW    0
`define CSPC_CTRL_MODE     2:1
`define CSPC_CTRL_DP       4:3
`define CSPC_CTRL_DM       6:5
`define CSPC_INPUT_LIMIT_SETTING_FIELD    4:0
`define CSPC_MODE_ON       2'h0
`define CSPC_INPUT_LIMIT_SETTING_500MA    5'h04
`define CSPC_INPUT_LIMIT_SETTING_2400MA   5'h17
`define CSPC_INPUT_LIMIT_SETTING_BASE_MA  12'h064
`define CSPC_INPUT_LIMIT_SETTING_STEP_MA  12'h064
`define CSPC_INPUT_LIMIT_SETTING_MIN_MA   12'h01e
`define CSPC_EV_W          3
`define CSPC_EV_UPD        0
`define CSPC_EV_FAULT      1
`define CSPC_EV_SUPPLY     2
`endif

// ### common/cspc_pkg.sv
// Purpose: Types of the charger status and pin control block
// Assumes: Constants come from cspc_params.svh
// Notes:   Nothing here is imported; users write cspc_pkg::name
package cspc_pkg;
  // -----------------------------------------------------------------
  // Charge core state, one bit per condition
  // -----------------------------------------------------------------
  typedef struct packed {
    logic in_progress; // Charge cycle running
    logic done;        // Charge completed
    logic sleep;       // Charger in sleep mode
    logic fault;       // Charge suspended by a fault
  } cspc_chg_t;

  // Input supply comparators
  typedef struct packed {
    logic above_undervolt_lockout;  // Above undervolt_lockout threshold
    logic overvolt;    // input_overvolt tripped
    logic above_sleep; // Above sleep threshold
  } cspc_vin_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;  // Byte address
    logic [7:0] wdata; // Write data
    logic       wr;    // Write strobe
    logic       rd;    // Read strobe
  } cspc_bus_t;

  // Status pin drive state
  typedef enum logic [1:0] {
    CSPC_ST_OFF   = 2'b00,
    CSPC_ST_ON    = 2'b01,
    CSPC_ST_BLINK = 2'b10
  } cspc_stat_t;
endpackage : cspc_pkg

// ### hdl/cspc_top.sv
// Purpose: Status pins, alert pulse and charge control of the charger
// Assumes: All inputs synchronous to clk_sys; open-drain pads outside
// Notes:   Open-drain pins show as out value plus output enable
`timescale 1ns/1ns
`include "cspc_params.svh"
module cspc_top #(
  // Alert pulse length in cycles
  parameter int unsigned ALERT_CYC = (`CSPC_CLK_HZ / 1000000) * `CSPC_ALERT_US,
  // Half period of the status blink in cycles
  parameter int unsigned BLINK_HALF = `CSPC_CLK_HZ / (2 * `CSPC_BLINK_HZ)
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Register port
  input  wire cspc_pkg::cspc_bus_t  bus_req,
  output logic [7:0]                bus_rdata,
  // Charge core and supply state
  input  wire cspc_pkg::cspc_chg_t  chg_state,
  input  wire logic                 status_update,
  input  wire cspc_pkg::cspc_vin_t  vin_state,
  // Pins in
  input  wire logic                 charge_allow_low,
  input  wire logic                 source_sel,
  // Open-drain pins out
  output logic                      stat_o,
  output logic                      stat_oe,
  output logic                      host_alert_n_o,
  output logic                      host_alert_n_oe,
  output logic                      supply_ok_n_o,
  output logic                      supply_ok_n_oe,
  // Controls to the power stage
  output logic                      charge_en,
  output logic [4:0]                input_limit_setting,
  output logic [1:0]                dplus_level,
  output logic [1:0]                dminus_level,
  // Interrupt
  output logic                      irq
);

  // -----------------------------------------------------------------
  // Functions
  // -----------------------------------------------------------------
  // Address match, used by read and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // Limit code to milliamps
  function automatic logic [11:0] code_ma(input logic [4:0] c);
    code_ma = `CSPC_INPUT_LIMIT_SETTING_BASE_MA + 12'(c) * `CSPC_INPUT_LIMIT_SETTING_STEP_MA;
  endfunction : code_ma

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [7:0]             ctrl_reg;     // Allow bit, mode, levels
  logic [4:0]             input_limit_setting_reg;     // input_current_limit_field
  logic                   input_limit_setting_ovr_reg; // Host has written the limit
  logic [`CSPC_EV_W-1:0]  int_stat_reg; // Sticky events
  logic [`CSPC_EV_W-1:0]  int_en_reg;   // Event enables
  logic [`CSPC_EV_W-1:0]  events;       // This cycle's events
  logic                   fault_reg;    // Fault, last cycle
  logic                   supply_reg;   // Supply good, last cycle
  logic [`CSPC_CNT_W-1:0] alert_cnt_reg;
  logic [`CSPC_CNT_W-1:0] blink_cnt_reg;
  logic                   blink_reg;    // Blink phase, 1 = pulled low
  cspc_pkg::cspc_stat_t   stat_reg;
  cspc_pkg::cspc_stat_t   stat_next;
  logic                   supply_good;

  // Field views
  logic       charge_allow_bit;
  logic [1:0] status_pin_mode;
  assign charge_allow_bit = ctrl_reg[`CSPC_CTRL_ALLOW];
  assign status_pin_mode  = ctrl_reg[`CSPC_CTRL_MODE];

  // -----------------------------------------------------------------
  // Register writes
  // -----------------------------------------------------------------
  // Control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= `CSPC_CTRL_RST;
    end else if (bus_req.wr && hit(bus_req.addr, `CSPC_A_CTRL)) begin
      ctrl_reg <= bus_req.wdata;
    end
  end

  // Limit field; a write marks the override for good
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      input_limit_setting_reg     <= 5'h00;
      input_limit_setting_ovr_reg <= 1'b0;
    end else if (bus_req.wr && hit(bus_req.addr, `CSPC_A_INPUT_LIMIT_SETTING)) begin
      input_limit_setting_reg     <= bus_req.wdata[`CSPC_INPUT_LIMIT_SETTING_FIELD]; // [R8]
      input_limit_setting_ovr_reg <= 1'b1;               // [R8]
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_en_reg <= '0;
    end else if (bus_req.wr && hit(bus_req.addr, `CSPC_A_INT_EN)) begin
      int_en_reg <= bus_req.wdata[`CSPC_EV_W-1:0];
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_stat_reg <= '0;
    end else if (bus_req.wr && hit(bus_req.addr, `CSPC_A_INT_CLR)) begin
      int_stat_reg <= (int_stat_reg & ~bus_req.wdata[`CSPC_EV_W-1:0]) | events;
    end else begin
      int_stat_reg <= int_stat_reg | events;
    end
  end

  assign irq = |(int_stat_reg & int_en_reg);

  // -----------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      if (hit(bus_req.addr, `CSPC_A_CTRL)) begin
        bus_rdata <= ctrl_reg;
      end else if (hit(bus_req.addr, `CSPC_A_INPUT_LIMIT_SETTING)) begin
        bus_rdata <= {input_limit_setting_ovr_reg, 2'h0, input_limit_setting};
      end else if (hit(bus_req.addr, `CSPC_A_STATUS)) begin
        bus_rdata <= {1'b0, charge_en, supply_good, blink_reg, chg_state};
      end else if (hit(bus_req.addr, `CSPC_A_INT_STAT)) begin
        bus_rdata <= {5'h00, int_stat_reg};
      end else if (hit(bus_req.addr, `CSPC_A_INT_EN)) begin
        bus_rdata <= {5'h00, int_en_reg};
      end else begin
        bus_rdata <= 8'h00; // Unmapped and write-only read as zero
      end
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // -----------------------------------------------------------------
  // Event detection
  // -----------------------------------------------------------------
  // Edge history for fault and supply state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_reg  <= 1'b0;
      supply_reg <= 1'b0;
    end else begin
      fault_reg  <= chg_state.fault;
      supply_reg <= supply_good;
    end
  end

  assign events[`CSPC_EV_UPD]    = status_update;
  assign events[`CSPC_EV_FAULT]  = chg_state.fault & ~fault_reg;
  assign events[`CSPC_EV_SUPPLY] = supply_good ^ supply_reg;

  // -----------------------------------------------------------------
  // Host alert pulse
  // -----------------------------------------------------------------
  // A new update or fault restarts the count, so the pin stays low a full width
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alert_cnt_reg <= '0;
    end else if (status_update || events[`CSPC_EV_FAULT]) begin
      alert_cnt_reg <= `CSPC_CNT_W'(ALERT_CYC); // [R5] [R12]
    end else if (alert_cnt_reg != '0) begin
      alert_cnt_reg <= alert_cnt_reg - `CSPC_CNT_W'(1); // [R12]
    end
  end

  assign host_alert_n_o  = 1'b0;                  // [R11]
  assign host_alert_n_oe = (alert_cnt_reg != '0); // [R5]

  // -----------------------------------------------------------------
  // Charge status pin
  // -----------------------------------------------------------------
  // Fault outranks charging; done and sleep release
  always_comb begin
    if (status_pin_mode != `CSPC_MODE_ON) begin
      stat_next = cspc_pkg::CSPC_ST_OFF;   // [R4]
    end else if (chg_state.fault) begin
      stat_next = cspc_pkg::CSPC_ST_BLINK; // [R3] [R12]
    end else if (chg_state.in_progress) begin
      stat_next = cspc_pkg::CSPC_ST_ON;    // [R1]
    end else begin
      stat_next = cspc_pkg::CSPC_ST_OFF;   // [R2]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_reg <= cspc_pkg::CSPC_ST_OFF;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // Blink timer restarts on entry so the first low phase is full
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else if (stat_reg != cspc_pkg::CSPC_ST_BLINK) begin
      blink_cnt_reg <= `CSPC_CNT_W'(BLINK_HALF - 1);
      blink_reg     <= 1'b1;
    end else if (blink_cnt_reg == '0) begin
      blink_cnt_reg <= `CSPC_CNT_W'(BLINK_HALF - 1); // [R3] [R12]
      blink_reg     <= ~blink_reg;                   // [R3]
    end else begin
      blink_cnt_reg <= blink_cnt_reg - `CSPC_CNT_W'(1);
    end
  end

  // Pin pulled low only, never driven high
  always_comb begin
    stat_o = 1'b0; // [R11]
    case (stat_reg)
      cspc_pkg::CSPC_ST_ON:    stat_oe = 1'b1;      // [R1]
      cspc_pkg::CSPC_ST_BLINK: stat_oe = blink_reg; // [R3]
      cspc_pkg::CSPC_ST_OFF:   stat_oe = 1'b0;      // [R2] [R4]
      default:                 stat_oe = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // Current limit, supply good, charge enable and data lines
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      input_limit_setting <= `CSPC_INPUT_LIMIT_SETTING_500MA;
    end else if (input_limit_setting_ovr_reg) begin
      input_limit_setting <= input_limit_setting_reg; // [R8]
    end else begin
      input_limit_setting <= source_sel ? `CSPC_INPUT_LIMIT_SETTING_500MA
                                        : `CSPC_INPUT_LIMIT_SETTING_2400MA; // [R7]
    end
  end

  // Good input window and a usable limit
  assign supply_good = vin_state.above_undervolt_lockout & ~vin_state.overvolt &
                       vin_state.above_sleep &
                       (code_ma(input_limit_setting) > `CSPC_INPUT_LIMIT_SETTING_MIN_MA); // [R9]
  assign supply_ok_n_o  = 1'b0;        // [R11]
  assign supply_ok_n_oe = supply_reg;  // [R9]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      charge_en    <= 1'b0;
      dplus_level  <= 2'h0;
      dminus_level <= 2'h0;
    end else begin
      charge_en    <= charge_allow_bit & ~charge_allow_low; // [R6]
      dplus_level  <= ctrl_reg[`CSPC_CTRL_DP]; // [R10]
      dminus_level <= ctrl_reg[`CSPC_CTRL_DM]; // [R10]
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  property p_alert_start;
    @(posedge clk_sys) disable iff (rst)
      status_update |=> host_alert_n_oe && alert_cnt_reg == `CSPC_CNT_W'(ALERT_CYC);
  endproperty
  a_alert_start: assert property (p_alert_start) else $error("alert not started"); // [R5]

  property p_alert_bound;
    @(posedge clk_sys) disable iff (rst)
      alert_cnt_reg <= `CSPC_CNT_W'(ALERT_CYC);
  endproperty
  a_alert_bound: assert property (p_alert_bound) else $error("alert too long"); // [R12]

  property p_alert_end;
    @(posedge clk_sys) disable iff (rst)
      (alert_cnt_reg == `CSPC_CNT_W'(1) && !status_update && !events[`CSPC_EV_FAULT])
      |=> !host_alert_n_oe;
  endproperty
  a_alert_end: assert property (p_alert_end) else $error("alert not ended"); // [R5]

  property p_stat_on;
    @(posedge clk_sys) disable iff (rst)
      (chg_state.in_progress && !chg_state.fault && status_pin_mode == `CSPC_MODE_ON)
      |=> stat_oe;
  endproperty
  a_stat_on: assert property (p_stat_on) else $error("status not low"); // [R1]

  property p_stat_off;
    @(posedge clk_sys) disable iff (rst)
      (!chg_state.in_progress && !chg_state.fault) |=> !stat_oe;
  endproperty
  a_stat_off: assert property (p_stat_off) else $error("status not released"); // [R2]

  property p_blink_steady;
    @(posedge clk_sys) disable iff (rst)
      (stat_reg == cspc_pkg::CSPC_ST_BLINK && $past(blink_cnt_reg) != '0 &&
       $past(stat_reg) == cspc_pkg::CSPC_ST_BLINK) |-> $stable(stat_oe);
  endproperty
  a_blink_steady: assert property (p_blink_steady) else $error("blink early"); // [R3]

  property p_mode_off;
    @(posedge clk_sys) disable iff (rst)
      (status_pin_mode != `CSPC_MODE_ON) |=> !stat_oe;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("status not disabled"); // [R4]

  property p_charge_en;
    @(posedge clk_sys) disable iff (rst)
      !rst |=> charge_en == ($past(charge_allow_bit) && !$past(charge_allow_low));
  endproperty
  a_charge_en: assert property (p_charge_en) else $error("charge enable wrong"); // [R6]

  property p_input_limit_setting_pin;
    @(posedge clk_sys) disable iff (rst)
      (!input_limit_setting_ovr_reg && source_sel) |=> input_limit_setting == `CSPC_INPUT_LIMIT_SETTING_500MA;
  endproperty
  a_input_limit_setting_pin: assert property (p_input_limit_setting_pin) else $error("pin limit wrong"); // [R7]

  property p_input_limit_setting_ovr;
    @(posedge clk_sys) disable iff (rst)
      (bus_req.wr && hit(bus_req.addr, `CSPC_A_INPUT_LIMIT_SETTING))
      |=> ##1 input_limit_setting == $past(bus_req.wdata[`CSPC_INPUT_LIMIT_SETTING_FIELD], 2);
  endproperty
  a_input_limit_setting_ovr: assert property (p_input_limit_setting_ovr) else $error("limit not taken"); // [R8]

  property p_supply;
    @(posedge clk_sys) disable iff (rst)
      (vin_state.overvolt || !vin_state.above_undervolt_lockout) |=> !supply_ok_n_oe;
  endproperty
  a_supply: assert property (p_supply) else $error("supply ok on bad input"); // [R9]

  property p_levels;
    @(posedge clk_sys) disable iff (rst)
      !rst |=> dplus_level == $past(ctrl_reg[`CSPC_CTRL_DP]) &&
               dminus_level == $past(ctrl_reg[`CSPC_CTRL_DM]);
  endproperty
  a_levels: assert property (p_levels) else $error("line level wrong"); // [R10]

  property p_open_drain;
    @(posedge clk_sys) disable iff (rst)
      !stat_o && !host_alert_n_o && !supply_ok_n_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high"); // [R11]

  c_blink: cover property (@(posedge clk_sys) disable iff (rst)
    stat_reg == cspc_pkg::CSPC_ST_BLINK && blink_cnt_reg == '0);
  c_alert: cover property (@(posedge clk_sys) disable iff (rst)
    $fell(host_alert_n_oe));
  c_override: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(input_limit_setting_ovr_reg));
  c_irq: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));

endmodule : cspc_top

// ### bench/cspc_host_model.sv
// Purpose: Host side of the open-drain status pins, with pull-ups
// Assumes: Host samples the pins on clk_sys like its own logic
// Notes:   Measures alert pulse width and flags any high drive
`timescale 1ns/1ns
module cspc_host_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Open-drain pins from the block
  input  wire logic        stat_o,
  input  wire logic        stat_oe,
  input  wire logic        host_alert_n_o,
  input  wire logic        host_alert_n_oe,
  input  wire logic        supply_ok_n_o,
  input  wire logic        supply_ok_n_oe,
  // Resolved pin levels and measurements
  output logic             stat_pin,
  output logic             alert_pin,
  output logic             supply_ok_pin,
  output logic [15:0]      alert_width,
  output logic             drove_high
);
  logic [15:0] low_cnt; // Cycles the alert line has been low so far

  // -----------------------------------------------------------------
  // Pull-ups: a released line reads high
  // -----------------------------------------------------------------
  assign stat_pin      = stat_oe ? stat_o : 1'b1;
  assign alert_pin     = host_alert_n_oe ? host_alert_n_o : 1'b1;
  assign supply_ok_pin = supply_ok_n_oe ? supply_ok_n_o : 1'b1;

  // Host times each alert pulse from its fall to its rise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_cnt     <= 16'h0000;
      alert_width <= 16'h0000;
    end else if (!alert_pin) begin
      low_cnt <= low_cnt + 16'h0001;
    end else if (low_cnt != 16'h0000) begin
      alert_width <= low_cnt;        // Latched once the line is back high
      low_cnt     <= 16'h0000;
    end
  end

  // A high drive would fight other open-drain parties on the net
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      drove_high <= 1'b0;
    end else if ((stat_oe && stat_o) || (host_alert_n_oe && host_alert_n_o)
                 || (supply_ok_n_oe && supply_ok_n_o)) begin
      drove_high <= 1'b1;
    end
  end
endmodule : cspc_host_model

// ### bench/testbench.sv
// Purpose: Self-checking bench of the charger status and pin block
// Assumes: Short counts ALERT_CYC 8 and BLINK_HALF 4 keep runs brief
// Notes:   Inputs move by non-blocking assignment at the rising edge
`timescale 1ns/1ns
`include "cspc_params.svh"
module testbench;
  localparam int AC = 8; // Alert length used here
  localparam int BH = 4; // Blink half period used here
  logic clk_sys, rst, status_update, charge_allow_low, source_sel;
  cspc_pkg::cspc_bus_t bus_req;   // Register port request
  cspc_pkg::cspc_chg_t chg_state; // Charge core state
  cspc_pkg::cspc_vin_t vin_state; // Supply comparators
  logic [7:0] bus_rdata, rv;
  logic [4:0] input_limit_setting;
  logic [1:0] dplus_level, dminus_level;
  logic stat_o, stat_oe, host_alert_n_o, host_alert_n_oe, supply_ok_n_o;
  logic supply_ok_n_oe, charge_en, irq, stat_pin, alert_pin, supply_ok_pin;
  logic drove_high;
  logic [15:0] alert_width;
  int mismatches, n_checks, n;

  cspc_top #(.ALERT_CYC(AC), .BLINK_HALF(BH)) cspc_top_inst (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .chg_state(chg_state), .status_update(status_update),
    .vin_state(vin_state), .charge_allow_low(charge_allow_low),
    .source_sel(source_sel), .stat_o(stat_o), .stat_oe(stat_oe),
    .host_alert_n_o(host_alert_n_o), .host_alert_n_oe(host_alert_n_oe),
    .supply_ok_n_o(supply_ok_n_o), .supply_ok_n_oe(supply_ok_n_oe),
    .charge_en(charge_en), .input_limit_setting(input_limit_setting),
    .dplus_level(dplus_level), .dminus_level(dminus_level), .irq(irq));

  cspc_host_model cspc_host_model_inst (
    .clk_sys(clk_sys), .rst(rst), .stat_o(stat_o), .stat_oe(stat_oe),
    .host_alert_n_o(host_alert_n_o), .host_alert_n_oe(host_alert_n_oe),
    .supply_ok_n_o(supply_ok_n_o), .supply_ok_n_oe(supply_ok_n_oe),
    .stat_pin(stat_pin), .alert_pin(alert_pin), .supply_ok_pin(supply_ok_pin),
    .alert_width(alert_width), .drove_high(drove_high));

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Four-state compare, zero-extended
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Let n edges pass, then settle
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr    <= 1'b0;
  endtask : wr

  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd   <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd

  // One-cycle status update pulse
  task automatic pulse();
    @(posedge clk_sys);
    status_update <= 1'b1;
    @(posedge clk_sys);
    status_update <= 1'b0;
  endtask : pulse

  // Cycles until the status pin changes; bounded so a stuck pin ends the run
  task automatic run_len(output int k);
    logic v;
    v = stat_pin;
    k = 0;
    while (stat_pin === v && k < 200) begin
      step(1);
      k++;
    end
    if (k >= 200) begin
      mismatches++;
      results();
    end
  endtask : run_len

  // Overall limit on run time
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    results();
  end

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0; rst = 1'b1; bus_req = '0; chg_state = '0;
    status_update = 1'b0; vin_state = '0; charge_allow_low = 1'b0;
    source_sel = 1'b1; mismatches = 0; n_checks = 0;
    step(16);
    chk(stat_oe, 1'b0);
    chk(host_alert_n_oe, 1'b0);
    chk(irq, 1'b0);
    chk(input_limit_setting, `CSPC_INPUT_LIMIT_SETTING_500MA);
    @(posedge clk_sys);
    rst <= 1'b0;
    step(3);
    // Register defaults, unmapped and write-only reads
    rd(`CSPC_A_CTRL, rv);    chk(rv, `CSPC_CTRL_RST);
    step(1);
    chk(bus_rdata, 8'h00);
    rd(8'h1c, rv);           chk(rv, 8'h00);
    rd(`CSPC_A_INT_CLR, rv); chk(rv, 8'h00);
    $display("Test registers ended");
    // Charge enable: allow bit against the active-low pin
    for (int i = 0; i < 4; i++) begin
      wr(`CSPC_A_CTRL, {7'h00, i[0]});
      @(posedge clk_sys);
      charge_allow_low <= i[1];
      step(2);
      chk(charge_en, i[0] & ~i[1]);
    end
    wr(`CSPC_A_CTRL, 8'h01);
    @(posedge clk_sys);
    charge_allow_low <= 1'b0;
    $display("Test charge enable ended");
    // Pin default limit, then a host override that sticks
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      source_sel <= s[0];
      step(2);
      chk(input_limit_setting, s ? `CSPC_INPUT_LIMIT_SETTING_500MA : `CSPC_INPUT_LIMIT_SETTING_2400MA);
    end
    wr(`CSPC_A_INPUT_LIMIT_SETTING, 8'h0a);
    @(posedge clk_sys);
    source_sel <= 1'b0;
    step(3);
    chk(input_limit_setting, 5'h0a);
    rd(`CSPC_A_INPUT_LIMIT_SETTING, rv); chk(rv, 8'h8a);
    $display("Test current limit ended");
    // Supply good only for the one good comparator pattern
    for (int v = 0; v < 8; v++) begin
      @(posedge clk_sys);
      vin_state <= v[2:0];
      step(3);
      chk(supply_ok_pin, (v == 5) ? 1'b0 : 1'b1);
    end
    $display("Test supply good ended");
    // Data line levels, every code on both lines
    for (int i = 0; i < 16; i++) begin
      wr(`CSPC_A_CTRL, {1'b0, i[3:2], i[1:0], 2'b00, 1'b1});
      step(2);
      chk(dplus_level, i[1:0]);
      chk(dminus_level, i[3:2]);
    end
    $display("Test data levels ended");
    // Status pin for each mode against each charge state; fault in mode on is driven but not checked
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        wr(`CSPC_A_CTRL, {5'h00, m[1:0], 1'b1});
        @(posedge clk_sys);
        chg_state <= 4'h8 >> c;
        step(3);
        if (!(m == 0 && c == 3)) chk(stat_pin, (m == 0 && c == 0) ? 1'b0 : 1'b1);
      end
    end
    $display("Test status pin ended");
    // Fault beside a running charge blinks at the half period
    wr(`CSPC_A_CTRL, 8'h01);
    @(posedge clk_sys);
    chg_state <= 4'h0;
    step(3);
    @(posedge clk_sys);
    chg_state <= 4'h9;
    step(2);
    chk(stat_pin, 1'b0);
    run_len(n);
    run_len(n); chk(n, BH);
    run_len(n); chk(n, BH);
    chk(alert_width, AC);
    $display("Test blink ended");
    // Alert from an update, then a restart in mid-pulse
    @(posedge clk_sys);
    chg_state <= 4'h0;
    pulse();
    step(AC + 3);
    chk(alert_width, AC);
    pulse();
    pulse();
    step(AC + 4);
    chk(alert_width, AC + 2);
    $display("Test alert ended");
    // Interrupt raise, mask and clear
    wr(`CSPC_A_INT_CLR, 8'h07);
    wr(`CSPC_A_INT_EN, 8'h07);
    step(2);
    chk(irq, 1'b0);
    pulse();
    step(2);
    chk(irq, 1'b1);
    rd(`CSPC_A_INT_STAT, rv); chk(rv, 8'h01);
    wr(`CSPC_A_INT_EN, 8'h00);
    step(2);
    chk(irq, 1'b0);
    rd(`CSPC_A_INT_STAT, rv); chk(rv, 8'h01);
    wr(`CSPC_A_INT_CLR, 8'h01);
    rd(`CSPC_A_INT_STAT, rv); chk(rv, 8'h00);
    wr(`CSPC_A_INT_EN, 8'h04);
    @(posedge clk_sys);
    vin_state <= 3'b101;
    step(4);
    chk(irq, 1'b1);
    rd(`CSPC_A_INT_STAT, rv); chk(rv, 8'h04);
    rd(`CSPC_A_STATUS, rv); chk(rv, 8'h70);
    $display("Test interrupts ended");
    chk(drove_high, 1'b0);
    results();
  end
endmodule : testbench
